// >>> design/bdrc_cfg.svh
// Constants for the balance result status register block: offsets, fields, codes.
`ifndef BDRC_CFG_SVH
`define BDRC_CFG_SVH

// Register word indices; the byte address is four times the index.
`define BDRC_IDX_RESULT 10'h083
`define BDRC_IDX_IRQ_STAT 10'h090
`define BDRC_IDX_IRQ_EN 10'h091
`define BDRC_IDX_IRQ_CLR 10'h092

// Fields of the balance result status register.
`define BDRC_BIT_STATE_HI 15
`define BDRC_BIT_STATE_LO 14
`define BDRC_BIT_READY 13
`define BDRC_BIT_STROBE 0
`define BDRC_LANE_READY 1
`define BDRC_LANE_STROBE 0
`define BDRC_LANE_IRQ 0
`define BDRC_RESULT_RST 16'h0000

// Balancing state codes.
`define BDRC_ST_DISABLED 2'h0
`define BDRC_ST_ACTIVE 2'h1
`define BDRC_ST_DONE 2'h2
`define BDRC_ST_HALT 2'h3

// Upper bit of the balancing state code; it is set in both end codes.
`define BDRC_STATE_END_BIT 1
// Edges between a state input change and its showing in read data.
`define BDRC_STATE_LAG 2

// Upper bit of the balancing-measurement enable field; 0x means disabled.
`define BDRC_MEAS_EN_BIT 1

// Interrupt event bits and their count.
`define BDRC_EV_READY 0
`define BDRC_EV_REFUSED 1
`define BDRC_EV_END 2
`define BDRC_EV_W 3
`define BDRC_EV_RST 3'h0

// Smallest APB address width accepted; it holds the full 10-bit word index.
`define BDRC_MIN_ADDR_W 12

`endif

// >>> design/bdrc_pkg.sv
// Types shared by the balance result status register block.
package bdrc_pkg;

  // States of the result transfer sequencer.
  typedef enum logic [0:0] {
    BDRC_XF_IDLE = 1'b0,
    BDRC_XF_WAIT = 1'b1
  } bdrc_xfer_e;

  // State of the transfer sequencer.
  typedef struct packed {
    bdrc_xfer_e state;
    logic req;
  } bdrc_xfer_s;

  // State of the register block.
  typedef struct packed {
    logic [1:0] bal_state;
    logic ready;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } bdrc_top_s;

endpackage

// >>> design/bdrc_xfer.sv
// Sequencer that asks the filter to copy its results and waits for the copy.
`timescale 1ns/100ps
`default_nettype none

module bdrc_xfer
  import bdrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic copy_done,
  output logic copy_req,
  output logic busy,
  output logic done
);

  bdrc_xfer_s st_r;
  bdrc_xfer_s st_nxt;

  // A start is a one-cycle copy request; then the sequencer waits for the done pulse.
  always_comb begin
    st_nxt = st_r;
    st_nxt.req = 1'b0;
    unique case (st_r.state)
      BDRC_XF_IDLE: begin
        if (start) begin
          st_nxt.state = BDRC_XF_WAIT;
          st_nxt.req = 1'b1;
        end
      end
      BDRC_XF_WAIT: begin
        if (copy_done) begin
          st_nxt.state = BDRC_XF_IDLE;
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{state: BDRC_XF_IDLE, req: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Busy covers the whole wait, so a second strobe cannot stack a request.
  assign copy_req = st_r.req;
  assign busy = (st_r.state == BDRC_XF_WAIT);
  assign done = busy & copy_done;

endmodule

`default_nettype wire

// >>> design/bdrc_top.sv
// Balance result status register with result transfer strobe, APB slave and interrupt.
//
// Functional notes
// [R1] Bits 15:14 show balancing state, read only.
// [R2] Bit 13 sets when results reach data registers.
// [R3] Writing 0 clears bit 13; 1 does nothing.
// [R4] Bit 13 always equals the scan setup flag.
// [R5] Mirror readable without the scan setup register.
// [R6] Strobe bit 0 copies filter results, then sets flag.
// [R7] Strobe self-clears and always reads zero.
// [R8] Strobe ignored in manual/disabled or enable 0x.
// [R9] Bits 12:1 read zero, writes ignored.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

`include "bdrc_cfg.svh"

module bdrc_top
  import bdrc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [1:0] BAL_STATE,
  input wire logic BAL_MODE_AUTO,
  input wire logic [1:0] BAL_MEAS_EN,
  input wire logic SCAN_RESULTS_MOVED,
  input wire logic SCAN_FLAG_CLR,
  input wire logic IIR_COPY_DONE,
  output logic IIR_COPY_REQ,
  output logic RESULTS_READY_FLAG,
  output logic IRQ
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************

  // Narrower addresses would cut the 10-bit word index short.
  if (ADDR_W < `BDRC_MIN_ADDR_W) begin : g_addr_chk
    $error("bdrc_top: ADDR_W too small for the register map");
  end

  // ****************************************************************
  // Declarations
  // ****************************************************************

  bdrc_top_s st_r;
  bdrc_top_s st_nxt;
  logic acc_ph;
  logic wr_acc;
  logic rd_ld;
  logic hit_result;
  logic hit_stat;
  logic hit_en;
  logic hit_clr;
  logic mapped;
  logic strobe_wr;
  logic strobe_ok;
  logic xfer_start;
  logic xfer_busy;
  logic xfer_done;
  logic xfer_req;
  logic ready_clr_sw;
  logic [`BDRC_EV_W-1:0] ev;
  logic [`BDRC_EV_W-1:0] irq_clr;

  // Word index compare; the two low address bits are ignored for aligned words.
  function automatic logic idx_is(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
    return a[ADDR_W-1:2] == (ADDR_W-2)'(idx);
  endfunction

  // Assembles the 16-bit result status word; every unused bit reads zero.
  function automatic logic [15:0] result_word(input logic [1:0] bst, input logic rdy);
    logic [15:0] w;
    w = `BDRC_RESULT_RST;
    w[`BDRC_BIT_STATE_HI:`BDRC_BIT_STATE_LO] = bst; // R1
    w[`BDRC_BIT_READY] = rdy; // R5
    w[`BDRC_BIT_STROBE] = 1'b0; // R7
    return w;
  endfunction

  // ****************************************************************
  // APB decode
  // ****************************************************************

  // One wait state: the access phase lasts two cycles and writes act at its end.
  assign acc_ph = PSEL & PENABLE;
  assign wr_acc = acc_ph & PWRITE & st_r.pready;
  assign rd_ld = acc_ph & ~PWRITE & ~st_r.pready;
  assign hit_result = idx_is(PADDR, `BDRC_IDX_RESULT);
  assign hit_stat = idx_is(PADDR, `BDRC_IDX_IRQ_STAT);
  assign hit_en = idx_is(PADDR, `BDRC_IDX_IRQ_EN);
  assign hit_clr = idx_is(PADDR, `BDRC_IDX_IRQ_CLR);
  assign mapped = hit_result | hit_stat | hit_en | hit_clr;

  // ****************************************************************
  // Result transfer strobe
  // ****************************************************************

  // The strobe is never stored, so it cannot be read back as one.
  assign strobe_wr = wr_acc & hit_result & PSTRB[`BDRC_LANE_STROBE] & PWDATA[`BDRC_BIT_STROBE]; // R7
  // Gating follows the balancing mode and measurement enable at the write edge.
  assign strobe_ok = BAL_MODE_AUTO & BAL_MEAS_EN[`BDRC_MEAS_EN_BIT] & ~xfer_busy; // R8
  assign xfer_start = strobe_wr & strobe_ok; // R6

  // Sequencer that owns the copy request and its completion.
  bdrc_xfer u_xfer (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .start(xfer_start),
    .copy_done(IIR_COPY_DONE),
    .copy_req(xfer_req),
    .busy(xfer_busy),
    .done(xfer_done)
  );

  // A write of 0 in the upper byte lane clears the flag; a 1 is a no-op.
  assign ready_clr_sw = wr_acc & hit_result & PSTRB[`BDRC_LANE_READY] & ~PWDATA[`BDRC_BIT_READY]; // R3

  // ****************************************************************
  // Interrupt events
  // ****************************************************************

  // Events: results ready, strobe refused, balancing state reached an end code.
  always_comb begin
    ev = `BDRC_EV_RST;
    ev[`BDRC_EV_READY] = SCAN_RESULTS_MOVED | xfer_done;
    ev[`BDRC_EV_REFUSED] = strobe_wr & ~strobe_ok;
    ev[`BDRC_EV_END] = BAL_STATE[`BDRC_STATE_END_BIT] & ~st_r.bal_state[`BDRC_STATE_END_BIT];
  end

  // Clear mask from a write to the write-only clear register.
  assign irq_clr = (wr_acc & hit_clr & PSTRB[`BDRC_LANE_IRQ]) ? PWDATA[`BDRC_EV_W-1:0] : `BDRC_EV_RST;

  // ****************************************************************
  // Next state
  // ****************************************************************

  // All state moves together; the set terms are ORed last so a set beats a clear.
  always_comb begin
    st_nxt = st_r;
    st_nxt.bal_state = BAL_STATE; // R1
    st_nxt.ready = (st_r.ready & ~ready_clr_sw & ~SCAN_FLAG_CLR) // R3 R4
                   | SCAN_RESULTS_MOVED | xfer_done; // R2 R6
    if (wr_acc & hit_en & PSTRB[`BDRC_LANE_IRQ]) begin
      st_nxt.irq_en = PWDATA[`BDRC_EV_W-1:0];
    end
    st_nxt.irq_stat = (st_r.irq_stat & ~irq_clr) | ev;
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_en);
    st_nxt.pready = acc_ph & ~st_r.pready;
    st_nxt.pslverr = acc_ph & ~st_r.pready & ~mapped;
    st_nxt.prdata = '0;
    if (rd_ld) begin
      if (hit_result) begin
        st_nxt.prdata = 32'(result_word(st_r.bal_state, st_r.ready)); // R9
      end else if (hit_stat) begin
        st_nxt.prdata[`BDRC_EV_W-1:0] = st_r.irq_stat;
      end else if (hit_en) begin
        st_nxt.prdata[`BDRC_EV_W-1:0] = st_r.irq_en;
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Every output below comes straight from this register or the sequencer's.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign PRDATA = st_r.prdata;
  assign PREADY = st_r.pready;
  assign PSLVERR = st_r.pslverr;
  assign IIR_COPY_REQ = xfer_req;
  assign RESULTS_READY_FLAG = st_r.ready; // R4
  assign IRQ = st_r.irq;

  // ****************************************************************
  // Assertions
  // ****************************************************************

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  // Read answer of the result register, sampled at the edge that ends it.
  logic rd_res_ans;
  logic wr_res_acc;
  assign rd_res_ans = acc_ph & ~PWRITE & st_r.pready & hit_result;
  assign wr_res_acc = wr_acc & hit_result;

  // State field on a read equals the balancing state two edges earlier.
  property p_state_read;
    rd_res_ans |-> PRDATA[`BDRC_BIT_STATE_HI:`BDRC_BIT_STATE_LO] == $past(BAL_STATE, `BDRC_STATE_LAG);
  endproperty
  a_state_read: assert property (p_state_read) else $error("state field wrong on read"); // R1

  // Results moved by the scan engine raise the flag on the next edge.
  property p_moved_sets;
    SCAN_RESULTS_MOVED |=> RESULTS_READY_FLAG;
  endproperty
  a_moved_sets: assert property (p_moved_sets) else $error("flag not set after results moved"); // R2

  // Writing 0 clears the flag unless a set arrives in the same cycle.
  property p_write0_clears;
    (wr_res_acc && PSTRB[`BDRC_LANE_READY] && !PWDATA[`BDRC_BIT_READY]
     && !SCAN_RESULTS_MOVED && !xfer_done) |=> !RESULTS_READY_FLAG;
  endproperty
  a_write0_clears: assert property (p_write0_clears) else $error("flag not cleared by write 0"); // R3

  // Writing 1 leaves a set flag set.
  property p_write1_keeps;
    (wr_res_acc && PWDATA[`BDRC_BIT_READY] && RESULTS_READY_FLAG && !SCAN_FLAG_CLR)
      |=> RESULTS_READY_FLAG;
  endproperty
  a_write1_keeps: assert property (p_write1_keeps) else $error("flag changed by write 1"); // R3

  // The mirror bit read back equals the shared flag.
  property p_mirror;
    rd_res_ans |-> PRDATA[`BDRC_BIT_READY] == $past(RESULTS_READY_FLAG);
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror differs from flag"); // R4

  // The result register always answers without error.
  property p_result_ok;
    rd_res_ans |-> !PSLVERR;
  endproperty
  a_result_ok: assert property (p_result_ok) else $error("error on result register read"); // R5

  // An accepted strobe requests one copy, and its completion sets the flag.
  property p_strobe_copy;
    xfer_start |=> IIR_COPY_REQ ##1 !IIR_COPY_REQ;
  endproperty
  a_strobe_copy: assert property (p_strobe_copy) else $error("copy request not a pulse"); // R6

  property p_copy_done_sets;
    (xfer_busy && IIR_COPY_DONE) |=> RESULTS_READY_FLAG;
  endproperty
  a_copy_done_sets: assert property (p_copy_done_sets) else $error("flag not set after copy"); // R6

  // The strobe bit and unused bits always read zero.
  property p_zero_bits;
    rd_res_ans |-> PRDATA[`BDRC_BIT_STROBE] == 1'b0 && PRDATA[`BDRC_BIT_READY-1:`BDRC_BIT_STROBE+1] == '0
                   && PRDATA[31:`BDRC_BIT_STATE_HI+1] == '0;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("reserved or strobe bit reads one"); // R7 R9

  // A strobe in manual or disabled mode, or with enable 0x, starts nothing.
  property p_strobe_refused;
    (strobe_wr && (!BAL_MODE_AUTO || !BAL_MEAS_EN[`BDRC_MEAS_EN_BIT]) && !xfer_busy)
      |=> !IIR_COPY_REQ && !xfer_busy;
  endproperty
  a_strobe_refused: assert property (p_strobe_refused) else $error("refused strobe started a copy"); // R8

  // Interrupt follows enabled status one edge after the event.
  property p_irq;
    (ev[`BDRC_EV_READY] && st_r.irq_en[`BDRC_EV_READY]) |=> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing for enabled event");

  // PREADY is a single-cycle answer, never held over into the next cycle.
  property p_pready_pulse;
    PREADY |=> !PREADY;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("ready held longer than one cycle");

  // Exactly one wait state: the first access cycle is always answered next.
  property p_one_wait;
    (PSEL && PENABLE && !PREADY) |=> PREADY;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("access not answered after one wait state");

  // The error flag marks exactly the unmapped addresses.
  property p_err_unmapped;
    (PSEL && PENABLE && !PREADY) |=> PSLVERR == !$past(mapped);
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("error flag wrong for address");

  // Read data is driven only with the answer, so a stale word cannot leak out.
  property p_rdata_idle;
    !PREADY |-> PRDATA == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside the answer cycle");

  // A copy request is only ever the echo of an accepted strobe.
  property p_req_cause;
    IIR_COPY_REQ |-> $past(xfer_start);
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("copy request without accepted strobe"); // R6

  // A strobe while a copy is pending must not stack a second request.
  property p_busy_no_restack;
    (strobe_wr && xfer_busy) |=> !IIR_COPY_REQ;
  endproperty
  a_busy_no_restack: assert property (p_busy_no_restack) else $error("second copy request while pending"); // R6

  // The flag only rises after results moved in or a copy finished.
  property p_flag_rise;
    $rose(RESULTS_READY_FLAG) |-> $past(SCAN_RESULTS_MOVED || xfer_done);
  endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag rose without a transfer"); // R2 R6

  // The flag only falls after a write of 0 or a clear from the scan setup register.
  property p_flag_fall;
    $fell(RESULTS_READY_FLAG) |-> $past(ready_clr_sw || SCAN_FLAG_CLR);
  endproperty
  a_flag_fall: assert property (p_flag_fall) else $error("flag fell without a clear"); // R3 R4

  // Balancing reaching an end code raises its status bit on the next edge.
  property p_end_event;
    (BAL_STATE[`BDRC_STATE_END_BIT] && !st_r.bal_state[`BDRC_STATE_END_BIT])
      |=> st_r.irq_stat[`BDRC_EV_END];
  endproperty
  a_end_event: assert property (p_end_event) else $error("end of balancing not flagged");

  // A clear write empties the chosen status bits when no event lands in the same cycle.
  property p_status_clear;
    (wr_acc && hit_clr && PSTRB[`BDRC_LANE_IRQ] && ev == `BDRC_EV_RST)
      |=> (st_r.irq_stat & $past(PWDATA[`BDRC_EV_W-1:0])) == `BDRC_EV_RST;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status bit survived its clear");

  // Main scenarios.
  c_transfer: cover property (xfer_start ##[1:20] xfer_done);
  c_busy_refused: cover property (strobe_wr && xfer_busy);
  c_refused: cover property (strobe_wr && !strobe_ok);
  c_clear_flag: cover property (RESULTS_READY_FLAG ##1 ready_clr_sw ##1 !RESULTS_READY_FLAG);
  c_irq: cover property (!IRQ ##1 IRQ);

endmodule

`default_nettype wire

// >>> sim/bdrc_top_tb.sv
// Self-checking testbench for the balance result status register block.
`timescale 1ns/100ps
`default_nettype none

`include "bdrc_cfg.svh"

module bdrc_top_tb;
  // ********************
  // Signals and instance
  // ********************
  localparam logic [11:0] A_RES = {`BDRC_IDX_RESULT, 2'b00};
  localparam logic [11:0] A_STAT = {`BDRC_IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_EN = {`BDRC_IDX_IRQ_EN, 2'b00};
  localparam logic [11:0] A_CLR = {`BDRC_IDX_IRQ_CLR, 2'b00};
  localparam logic [11:0] A_BAD = 12'h210;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [3:0] PSTRB = 4'h0;
  logic [1:0] BAL_STATE = 2'h0;
  logic [1:0] BAL_MEAS_EN = 2'h0;
  logic BAL_MODE_AUTO = 1'b0;
  logic SCAN_RESULTS_MOVED = 1'b0;
  logic SCAN_FLAG_CLR = 1'b0;
  logic IIR_COPY_DONE = 1'b0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic IIR_COPY_REQ;
  logic RESULTS_READY_FLAG;
  logic IRQ;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int reqs = 0;
  int n0 = 0;
  logic [31:0] rd;
  logic err;

  bdrc_top #(.ADDR_W(12)) uut (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .BAL_STATE(BAL_STATE), .BAL_MODE_AUTO(BAL_MODE_AUTO),
    .BAL_MEAS_EN(BAL_MEAS_EN), .SCAN_RESULTS_MOVED(SCAN_RESULTS_MOVED),
    .SCAN_FLAG_CLR(SCAN_FLAG_CLR), .IIR_COPY_DONE(IIR_COPY_DONE), .IIR_COPY_REQ(IIR_COPY_REQ),
    .RESULTS_READY_FLAG(RESULTS_READY_FLAG), .IRQ(IRQ)
  );

  // The clock toggles every half period of 5 ns.
  always #5 REF_CLK = ~REF_CLK;

  // Count copy requests and cut a hang short; a run needs well under a thousand cycles.
  always @(posedge REF_CLK) begin
    cycles++;
    if (IIR_COPY_REQ === 1'b1) reqs++;
    if (cycles == 5000) begin
      failures++;
      give_verdict();
    end
  end

  // *****
  // Tasks
  // *****
  // Compare one value and report a mismatch at once.
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One APB transfer; the request holds until PREADY is seen high at a rising edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= s;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    // Only the bench timeout ends a wait that never gets its answer.
    do begin
      @(posedge REF_CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, a, d, s);
  endtask

  task rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    cmp(rd, e);
  endtask

  // Pulse one event input for a single cycle: 0 moved, 1 flag clear, 2 copy done.
  task pulse(input int k);
    SCAN_RESULTS_MOVED <= (k == 0);
    SCAN_FLAG_CLR <= (k == 1);
    IIR_COPY_DONE <= (k == 2);
    @(posedge REF_CLK);
    SCAN_RESULTS_MOVED <= 1'b0;
    SCAN_FLAG_CLR <= 1'b0;
    IIR_COPY_DONE <= 1'b0;
    @(posedge REF_CLK);
  endtask

  task give_verdict();
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ********
  // Sequence
  // ********
  initial begin
    repeat (8) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    rd_chk(A_RES, 32'h0);
    rd_chk(A_STAT, 32'h0);
    rd_chk(A_CLR, 32'h0);
    // Every balancing state code must show in the top two bits.
    for (int i = 0; i < 4; i++) begin
      BAL_STATE <= 2'(i);
      repeat (2) @(posedge REF_CLK);
      rd_chk(A_RES, 32'(i) << 14);
    end
    rd_chk(A_STAT, 32'h4);
    wr(A_RES, 32'h0, 4'h3);
    rd_chk(A_RES, 32'hc000);
    BAL_STATE <= 2'h0;
    apb(1'b0, A_BAD, 32'h0, 4'h0);
    cmp({31'h0, err}, 32'h1);
    cmp(rd, 32'h0);
    wr(A_CLR, 32'h7, 4'h1);
    rd_chk(A_STAT, 32'h0);
    wr(A_EN, 32'h7, 4'h1);
    rd_chk(A_EN, 32'h7);
    // Results moved in, then a write of 1 keeps the flag and a write of 0 clears it.
    pulse(0);
    cmp({31'h0, RESULTS_READY_FLAG}, 32'h1);
    rd_chk(A_RES, 32'h2000);
    rd_chk(A_STAT, 32'h1);
    cmp({31'h0, IRQ}, 32'h1);
    wr(A_RES, 32'h2000, 4'h3);
    rd_chk(A_RES, 32'h2000);
    wr(A_RES, 32'h0, 4'h3);
    rd_chk(A_RES, 32'h0);
    cmp({31'h0, RESULTS_READY_FLAG}, 32'h0);
    pulse(0);
    pulse(1);
    rd_chk(A_RES, 32'h0);
    // A strobe in automated mode with measurement enabled asks for one copy.
    BAL_MODE_AUTO <= 1'b1;
    BAL_MEAS_EN <= 2'h2;
    wr(A_CLR, 32'h7, 4'h1);
    n0 = reqs;
    wr(A_RES, 32'h1, 4'h1);
    repeat (3) @(posedge REF_CLK);
    cmp(32'(reqs), 32'(n0 + 1));
    rd_chk(A_RES, 32'h0);
    wr(A_RES, 32'h1, 4'h1);
    repeat (2) @(posedge REF_CLK);
    cmp(32'(reqs), 32'(n0 + 1));
    pulse(2);
    rd_chk(A_RES, 32'h2000);
    // Refused strobes: manual mode, enable 00, enable 01; last a zero strobe with loose bits set.
    n0 = reqs;
    for (int k = 0; k < 4; k++) begin
      BAL_MODE_AUTO <= (k != 0);
      BAL_MEAS_EN <= (k == 1) ? 2'h0 : (k == 2) ? 2'h1 : 2'h2;
      wr(A_RES, (k < 3) ? 32'h2001 : 32'h3ffe, 4'h3);
      repeat (3) @(posedge REF_CLK);
      cmp(32'(reqs), 32'(n0));
    end
    rd_chk(A_RES, 32'h2000);
    rd_chk(A_STAT, 32'h3);
    // Masking holds the interrupt low; clearing the status drops it.
    wr(A_EN, 32'h0, 4'h1);
    repeat (2) @(posedge REF_CLK);
    cmp({31'h0, IRQ}, 32'h0);
    wr(A_EN, 32'h7, 4'h1);
    repeat (2) @(posedge REF_CLK);
    cmp({31'h0, IRQ}, 32'h1);
    wr(A_CLR, 32'h7, 4'h1);
    repeat (2) @(posedge REF_CLK);
    cmp({31'h0, IRQ}, 32'h0);
    rd_chk(A_STAT, 32'h0);
    give_verdict();
  end
endmodule

`default_nettype wire
